// ==== edc_consts.svh ====
/*
 * offsets, bit positions, masks, reset values and bus codes of the
 * extended device control register. assumes inclusion by bare name.
 */
`ifndef EDC_CONSTS_SVH
`define EDC_CONSTS_SVH
`define EDC_EXT_CTRL_OFFSET 32'h0000_0018
`define EDC_BIT_SPEED_DETECT 12
`define EDC_BIT_NVM_RELOAD 13
`define EDC_BIT_SPEED_BYPASS 15
`define EDC_BIT_RO_DISABLE 17
`define EDC_BIT_DYN_GATE 19
`define EDC_BIT_PHY_LOW_POWER 20
`define EDC_BIT_SEG_FLOW 22
`define EDC_BIT_SEG 23
`define EDC_BIT_EXT_AUTO_MASK 24
`define EDC_BIT_CAUSE_AUTO_MASK 27
`define EDC_BIT_DRIVER_PRESENT 28
`define EDC_BIT_TIMER_CLEAR 29
`define EDC_BIT_PENDING_CLEAR 31
`define EDC_WRITE_MASK 32'hB9DB_C000
`define EDC_NVM_MASK 32'h00D9_4000
`define EDC_RESET_VALUE 32'h0010_0000
`define EDC_RESP_OKAY 2'h0
`define EDC_RESP_SLVERR 2'h2
`endif

// ==== edc_pkg.sv ====
/*
 * types of the extended device control block.
 * assumes nothing of its surroundings.
 */
`default_nettype none
package edc_pkg;
    typedef enum logic [1:0] {
        EDC_TRIG_IDLE = 2'h1,
        EDC_TRIG_WAIT = 2'h2
    } edc_trig_state_type;
endpackage : edc_pkg
`default_nettype wire

// ==== edc_trigger.sv ====
/*
 * one-shot launcher for a self-clearing action: pulses start and waits
 * for done. assumes done comes no earlier than the cycle start is high.
 */
`default_nettype none
module edc_trigger
    import edc_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fire,
    input wire logic done,
    output logic start_q,
    output logic busy_q
);
    edc_trig_state_type state_q;

    // a fire while busy is dropped
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= EDC_TRIG_IDLE;
            start_q <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            case (state_q)
                EDC_TRIG_IDLE:
                begin
                    if (fire)
                    begin
                        state_q <= EDC_TRIG_WAIT;
                        start_q <= 1'b1;
                        busy_q <= 1'b1;
                    end
                end
                EDC_TRIG_WAIT:
                begin
                    if (done)
                    begin
                        state_q <= EDC_TRIG_IDLE;
                        busy_q <= 1'b0;
                    end
                end
                default:
                begin
                    state_q <= EDC_TRIG_IDLE;
                    busy_q <= 1'b0;
                end
            endcase
        end
    end
endmodule : edc_trigger
`default_nettype wire

// ==== edc_bar_shadow.sv ====
/*
 * holds base address settings staged by a memory reload until reboot.
 * assumes commit is a one-cycle pulse at system reboot.
 */
`default_nettype none
module edc_bar_shadow
    import edc_pkg::*;
#(
    parameter int BAR_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic stage_valid,
    input wire logic [BAR_W-1:0] stage_data,
    input wire logic commit,
    output logic [BAR_W-1:0] visible_q
);
    logic [BAR_W-1:0] staged_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            staged_q <= '0;
        else if (stage_valid)
            staged_q <= stage_data;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            visible_q <= '0;
        else if (commit)
            visible_q <= stage_valid ? stage_data : staged_q;
    end
endmodule : edc_bar_shadow
`default_nettype wire

// ==== edc_ext_ctrl.sv ====
/*
 * extended device control register on an axi4-lite slave, with its
 * triggers and the side effects it steers in interrupt, clock and phy
 * logic. assumes a single clock, a memory loader that presents initial
 * bits, and helpers that answer start pulses with done pulses.
 */
// Functional notes
// - bit 12 launches speed detect, self-clears
// - bit 13 reloads nvm, self-clears
// - bit 15 bypasses detection, applies forced speed
// - bit 17 blocks relaxed ordering requests
// - bit 19 enables dynamic dma/mac clock gating
// - bit 20, reset one, allows phy low power
// - bit 24 chooses when extended auto-mask applies
// - bit 27 copies auto-mask on cause access
// - bit 28 driver flag, cleared by soft reset
// - bit 29 clears interrupt timers with mask clear
// - bit 31 clears pending bits on mask set
// - nvm reload rewrites control register values
// - reloaded base addresses wait for reboot
// - nvm-loaded bits take their initial values
`default_nettype none
`include "edc_consts.svh"
module edc_ext_ctrl
    import edc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int SPEED_W = 2,
    parameter int MASK_W = 32,
    parameter int BAR_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic nvm_load_valid,
    input wire logic [31:0] nvm_load_data,
    input wire logic soft_reset,
    output logic speed_detect_start,
    input wire logic speed_detect_done,
    input wire logic [SPEED_W-1:0] speed_detect_result,
    output logic [SPEED_W-1:0] detected_speed_field,
    output logic speed_detect_bypass,
    input wire logic force_speed_bit,
    input wire logic [SPEED_W-1:0] ctrl_speed,
    output logic [SPEED_W-1:0] applied_speed,
    output logic nvm_reload_start,
    input wire logic nvm_reload_done,
    output logic nvm_reload_busy,
    input wire logic pcie_ro_enable,
    output logic relaxed_order_req_en,
    output logic dyn_clock_gate_en,
    output logic phy_low_power_en,
    output logic seg_offload_flow_setting,
    output logic seg_offload_setting,
    input wire logic msix_fire,
    input wire logic [MASK_W-1:0] msix_fire_auto_mask,
    input wire logic ext_cause_read,
    input wire logic [MASK_W-1:0] ext_auto_mask_reg,
    output logic [MASK_W-1:0] ext_auto_mask_clear,
    output logic ext_auto_mask_clear_valid,
    input wire logic irq_cause_access,
    input wire logic [MASK_W-1:0] auto_mask_reg,
    output logic irq_mask_clear_wr,
    output logic [MASK_W-1:0] irq_mask_clear_data,
    input wire logic irq_mask_clear_event,
    output logic irq_timer_clear,
    input wire logic irq_mask_set_wr,
    input wire logic [MASK_W-1:0] irq_mask_set_data,
    output logic [MASK_W-1:0] vector_pending_clear,
    output logic driver_present_flag,
    input wire logic nvm_bar_valid,
    input wire logic [BAR_W-1:0] nvm_bar_data,
    input wire logic system_reboot,
    output logic [BAR_W-1:0] bar_config
);
    localparam logic [ADDR_W-1:0] REG_ADDR =
        ADDR_W'(`EDC_EXT_CTRL_OFFSET);

    logic [31:0] extended_device_control_q;
    logic [31:0] extended_device_control_d;
    logic [31:0] strb_mask;
    logic [31:0] merged;
    logic aw_held_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_held_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    logic wr_hit;
    logic rd_hit;
    logic asd_fire;
    logic asd_busy;
    logic reload_fire;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [SPEED_W-1:0] detected_q;
    logic [SPEED_W-1:0] applied_q;
    logic ro_req_q;
    logic [MASK_W-1:0] ext_clear_q;
    logic ext_clear_valid_q;
    logic mask_clear_wr_q;
    logic [MASK_W-1:0] mask_clear_data_q;
    logic timer_clear_q;
    logic [MASK_W-1:0] pending_clear_q;

    assign wr_go = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_hit = {aw_addr_q[ADDR_W-1:2], 2'h0} == REG_ADDR;
    assign rd_hit = {s_axi_araddr[ADDR_W-1:2], 2'h0} == REG_ADDR;

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            strb_mask[i*8 +: 8] = {8{w_strb_q[i]}};
    end

    assign merged = (extended_device_control_q & ~strb_mask) |
        (w_data_q & strb_mask);

    // write address and data are taken independently, one write at a time
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_q <= 1'b0;
            aw_addr_q <= '0;
            awready_q <= 1'b1;
        end
        else if (s_axi_awvalid && awready_q)
        begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            awready_q <= 1'b0;
        end
        else if (wr_go)
            aw_held_q <= 1'b0;
        else if (bvalid_q && s_axi_bready)
            awready_q <= 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
            wready_q <= 1'b1;
        end
        else if (s_axi_wvalid && wready_q)
        begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            wready_q <= 1'b0;
        end
        else if (wr_go)
            w_held_q <= 1'b0;
        else if (bvalid_q && s_axi_bready)
            wready_q <= 1'b1;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `EDC_RESP_OKAY;
        end
        else if (wr_go)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `EDC_RESP_OKAY : `EDC_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    // read answers one cycle after the address is taken
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rresp_q <= `EDC_RESP_OKAY;
            rdata_q <= '0;
        end
        else if (s_axi_arvalid && arready_q)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= rd_hit ? `EDC_RESP_OKAY : `EDC_RESP_SLVERR;
            rdata_q <= rd_hit ? extended_device_control_q : 32'h0000_0000;
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // only implemented bits are stored; triggers never are
    always_comb
    begin
        extended_device_control_d = extended_device_control_q;
        if (wr_go && wr_hit)
            extended_device_control_d = merged & `EDC_WRITE_MASK;
        if (nvm_load_valid)
            extended_device_control_d =
                (extended_device_control_d & ~`EDC_NVM_MASK) |
                (nvm_load_data & `EDC_NVM_MASK);
        if (soft_reset)
            extended_device_control_d[`EDC_BIT_DRIVER_PRESENT] = 1'b0;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            extended_device_control_q <= `EDC_RESET_VALUE;
        else
            extended_device_control_q <= extended_device_control_d;
    end

    // a detect request under bypass is dropped
    assign asd_fire = wr_go && wr_hit && w_strb_q[1] &&
        w_data_q[`EDC_BIT_SPEED_DETECT] &&
        !merged[`EDC_BIT_SPEED_BYPASS];
    assign reload_fire = wr_go && wr_hit && w_strb_q[1] &&
        w_data_q[`EDC_BIT_NVM_RELOAD];

    edc_trigger u_speed_detect (
        .clock(clock),
        .rst_n(rst_n),
        .fire(asd_fire),
        .done(speed_detect_done),
        .start_q(speed_detect_start),
        .busy_q(asd_busy)
    );

    edc_trigger u_nvm_reload (
        .clock(clock),
        .rst_n(rst_n),
        .fire(reload_fire),
        .done(nvm_reload_done),
        .start_q(nvm_reload_start),
        .busy_q(nvm_reload_busy)
    );

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            detected_q <= '0;
        else if (asd_busy && speed_detect_done)
            detected_q <= speed_detect_result;
    end

    // bypass applies the software speed at once; force waits for detect
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            applied_q <= '0;
        else if (extended_device_control_q[`EDC_BIT_SPEED_BYPASS])
            applied_q <= ctrl_speed;
        else if (force_speed_bit && !asd_busy)
            applied_q <= ctrl_speed;
        else if (asd_busy && speed_detect_done)
            applied_q <= speed_detect_result;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            ro_req_q <= 1'b0;
        else
            ro_req_q <= pcie_ro_enable &&
                !extended_device_control_q[`EDC_BIT_RO_DISABLE];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_clear_q <= '0;
            ext_clear_valid_q <= 1'b0;
        end
        else if (extended_device_control_q[`EDC_BIT_EXT_AUTO_MASK])
        begin
            ext_clear_q <= msix_fire ? msix_fire_auto_mask : '0;
            ext_clear_valid_q <= msix_fire;
        end
        else
        begin
            ext_clear_q <= ext_cause_read ? ext_auto_mask_reg : '0;
            ext_clear_valid_q <= ext_cause_read;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_clear_wr_q <= 1'b0;
            mask_clear_data_q <= '0;
        end
        else
        begin
            mask_clear_wr_q <= irq_cause_access &&
                extended_device_control_q[`EDC_BIT_CAUSE_AUTO_MASK];
            mask_clear_data_q <= auto_mask_reg;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            timer_clear_q <= 1'b0;
        else
            timer_clear_q <= irq_mask_clear_event &&
                extended_device_control_q[`EDC_BIT_TIMER_CLEAR];
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            pending_clear_q <= '0;
        else if (irq_mask_set_wr &&
            extended_device_control_q[`EDC_BIT_PENDING_CLEAR])
            pending_clear_q <= irq_mask_set_data;
        else
            pending_clear_q <= '0;
    end

    edc_bar_shadow #(
        .BAR_W(BAR_W)
    ) u_bar_shadow (
        .clock(clock),
        .rst_n(rst_n),
        .stage_valid(nvm_bar_valid),
        .stage_data(nvm_bar_data),
        .commit(system_reboot),
        .visible_q(bar_config)
    );

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;
    assign detected_speed_field = detected_q;
    assign applied_speed = applied_q;
    assign relaxed_order_req_en = ro_req_q;
    assign ext_auto_mask_clear = ext_clear_q;
    assign ext_auto_mask_clear_valid = ext_clear_valid_q;
    assign irq_mask_clear_wr = mask_clear_wr_q;
    assign irq_mask_clear_data = mask_clear_data_q;
    assign irq_timer_clear = timer_clear_q;
    assign vector_pending_clear = pending_clear_q;
    assign speed_detect_bypass =
        extended_device_control_q[`EDC_BIT_SPEED_BYPASS];
    assign dyn_clock_gate_en =
        extended_device_control_q[`EDC_BIT_DYN_GATE];
    assign phy_low_power_en =
        extended_device_control_q[`EDC_BIT_PHY_LOW_POWER];
    assign seg_offload_flow_setting =
        extended_device_control_q[`EDC_BIT_SEG_FLOW];
    assign seg_offload_setting = extended_device_control_q[`EDC_BIT_SEG];
    assign driver_present_flag =
        extended_device_control_q[`EDC_BIT_DRIVER_PRESENT];
endmodule : edc_ext_ctrl
`default_nettype wire

// ==== edc_ext_ctrl_chk.sv ====
/* assertions on the extended device control ports.
   bound to edc_ext_ctrl; one clock, rst_n active low. */
`default_nettype none
module edc_ext_ctrl_chk
    import edc_pkg::*;
#(
    parameter int SPEED_W = 2,
    parameter int MASK_W = 32
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic speed_detect_start,
    input wire logic nvm_reload_busy,
    input wire logic nvm_reload_done,
    input wire logic speed_detect_bypass,
    input wire logic [SPEED_W-1:0] ctrl_speed,
    input wire logic [SPEED_W-1:0] applied_speed,
    input wire logic pcie_ro_enable,
    input wire logic relaxed_order_req_en,
    input wire logic msix_fire,
    input wire logic ext_cause_read,
    input wire logic ext_auto_mask_clear_valid,
    input wire logic irq_cause_access,
    input wire logic [MASK_W-1:0] auto_mask_reg,
    input wire logic irq_mask_clear_wr,
    input wire logic [MASK_W-1:0] irq_mask_clear_data,
    input wire logic irq_mask_clear_event,
    input wire logic irq_timer_clear,
    input wire logic irq_mask_set_wr,
    input wire logic [MASK_W-1:0] irq_mask_set_data,
    input wire logic [MASK_W-1:0] vector_pending_clear,
    input wire logic soft_reset,
    input wire logic driver_present_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    sequence wr_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence start_pulse_s;
        $rose(s_axi_bvalid) ##1 !speed_detect_start;
    endsequence
    write_resp_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
        else $error("write response not on time");
    trig_start_a: assert property (
        speed_detect_start |-> start_pulse_s)
        else $error("detect start not a write pulse");
    reload_hold_a: assert property (
        nvm_reload_busy && !nvm_reload_done |=> nvm_reload_busy)
        else $error("reload busy dropped early");
    bypass_speed_a: assert property (
        speed_detect_bypass |=> applied_speed == $past(ctrl_speed))
        else $error("bypass speed not applied");
    ro_block_a: assert property (
        !$past(pcie_ro_enable) |-> !relaxed_order_req_en)
        else $error("relaxed ordering without enable");
    ext_mask_a: assert property (
        ext_auto_mask_clear_valid |-> $past(msix_fire)
        || $past(ext_cause_read))
        else $error("auto mask clear without cause");
    cause_copy_a: assert property (
        irq_mask_clear_wr |-> $past(irq_cause_access)
        && irq_mask_clear_data == $past(auto_mask_reg))
        else $error("mask clear copy wrong");
    driver_clear_a: assert property (
        soft_reset |=> !driver_present_flag)
        else $error("driver flag kept over soft reset");
    timer_clear_a: assert property (
        irq_timer_clear |-> $past(irq_mask_clear_event))
        else $error("timer clear without mask clear");
    pending_clear_a: assert property (
        vector_pending_clear != '0 |-> $past(irq_mask_set_wr)
        && vector_pending_clear == $past(irq_mask_set_data))
        else $error("pending clear wrong");
endmodule : edc_ext_ctrl_chk
`default_nettype wire

// ==== edc_ext_ctrl_tb.sv ====
/* directed bench for the extended device control register over axi4-lite.
   assumes edc_pkg, edc_consts.svh and the checker compiled first. */
`default_nettype none
`include "edc_consts.svh"
module testbench
    import edc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SPEED_W = 2;
    localparam int MASK_W = 32;
    localparam logic [7:0] REG_A = 8'(`EDC_EXT_CTRL_OFFSET);
    logic clock, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, nvm_load_data, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready, nvm_load_valid;
    logic soft_reset, speed_detect_start, speed_detect_done;
    logic [SPEED_W-1:0] speed_detect_result, detected_speed_field;
    logic [SPEED_W-1:0] ctrl_speed, applied_speed;
    logic speed_detect_bypass, force_speed_bit, nvm_reload_start;
    logic nvm_reload_done, nvm_reload_busy, pcie_ro_enable;
    logic relaxed_order_req_en, dyn_clock_gate_en, phy_low_power_en;
    logic seg_offload_flow_setting, seg_offload_setting, msix_fire;
    logic ext_cause_read, ext_auto_mask_clear_valid, irq_cause_access;
    logic irq_mask_clear_wr, irq_mask_clear_event, irq_timer_clear;
    logic irq_mask_set_wr, driver_present_flag, nvm_bar_valid;
    logic system_reboot;
    logic [MASK_W-1:0] msix_fire_auto_mask, ext_auto_mask_reg;
    logic [MASK_W-1:0] auto_mask_reg, ext_auto_mask_clear;
    logic [MASK_W-1:0] irq_mask_clear_data, irq_mask_set_data;
    logic [MASK_W-1:0] vector_pending_clear;
    logic [31:0] nvm_bar_data, bar_config;
    int n_errors = 0;
    int checks = 0;
    int n_sd = 0;
    int n_nr = 0;

    edc_ext_ctrl #(.ADDR_W(8), .SPEED_W(SPEED_W), .MASK_W(MASK_W),
        .BAR_W(32)) DUT (.*);

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // counts launch pulses of the two self-clearing triggers
    always @(posedge clock)
    begin
        if (speed_detect_start)
            n_sd <= n_sd + 1;
        if (nvm_reload_start)
            n_nr <= n_nr + 1;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
        input logic [1:0] er);
        logic aw_ok, w_ok;
        @(posedge clock);
        aw_ok = 1'b0;
        w_ok = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge clock);
            if (!aw_ok && s_axi_awready)
            begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready)
            begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed,
        input logic [1:0] er);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : axi_read

    initial
    begin
        repeat (4000) @(posedge clock);
        n_errors++;
        $display("Error at %0t: timeout", $time);
        end_of_test();
    end

    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
            s_axi_rready, nvm_load_valid, soft_reset, speed_detect_done,
            force_speed_bit, nvm_reload_done, msix_fire, ext_cause_read,
            irq_cause_access, irq_mask_clear_event, irq_mask_set_wr,
            nvm_bar_valid, system_reboot, rst_n} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, nvm_load_data,
            speed_detect_result, ctrl_speed, nvm_bar_data} = '0;
        s_axi_wstrb = 4'hF;
        pcie_ro_enable = 1'b1;
        msix_fire_auto_mask = 32'h0000_00A5;
        ext_auto_mask_reg = 32'h0000_5A00;
        auto_mask_reg = 32'h00C3_0000;
        irq_mask_set_data = 32'h3C00_0000;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        axi_read(REG_A, `EDC_RESET_VALUE, `EDC_RESP_OKAY);
        chk(phy_low_power_en, 1'b1);
        chk(relaxed_order_req_en, 1'b1);
        pcie_ro_enable <= 1'b0;
        repeat (2) @(posedge clock);
        chk(relaxed_order_req_en, 1'b0);
        pcie_ro_enable <= 1'b1;
        // writable bits; triggers, 14, 16 and 23 held clear
        axi_write(REG_A, 32'hFF7E_8FFF, `EDC_RESP_OKAY);
        repeat (2) @(posedge clock);
        chk(relaxed_order_req_en, 1'b0);
        chk(dyn_clock_gate_en, 1'b1);
        chk(driver_present_flag, 1'b1);
        soft_reset <= 1'b1;
        @(posedge clock);
        soft_reset <= 1'b0;
        @(posedge clock);
        chk(driver_present_flag, 1'b0);
        axi_write(8'h1C, 32'h0, `EDC_RESP_SLVERR);
        axi_read(8'h1C, 32'h0, `EDC_RESP_SLVERR);
        axi_read(REG_A, `EDC_WRITE_MASK & 32'hEF7E_BFFF, 2'h0);
        ctrl_speed <= 2'h2;
        axi_write(REG_A, 32'h0000_9000, `EDC_RESP_OKAY);
        ctrl_speed <= 2'h3;
        repeat (2) @(posedge clock);
        chk(32'(applied_speed), 32'h3);
        chk(n_sd, 0);
        chk(speed_detect_bypass, 1'b1);
        axi_write(REG_A, 32'h0000_1000, `EDC_RESP_OKAY);
        repeat (2) @(posedge clock);
        chk(n_sd, 1);
        chk(phy_low_power_en, 1'b0);
        chk(dyn_clock_gate_en, 1'b0);
        speed_detect_result <= 2'h1;
        speed_detect_done <= 1'b1;
        @(posedge clock);
        speed_detect_done <= 1'b0;
        @(posedge clock);
        chk(32'(detected_speed_field), 32'h1);
        chk(32'(applied_speed), 32'h1);
        axi_read(REG_A, 32'h0, `EDC_RESP_OKAY);
        axi_write(REG_A, 32'h0000_2000, `EDC_RESP_OKAY);
        repeat (2) @(posedge clock);
        chk(n_nr, 1);
        chk(nvm_reload_busy, 1'b1);
        {nvm_load_valid, nvm_reload_done, nvm_bar_valid} <= 3'h7;
        nvm_load_data <= 32'hFFFF_FFFF;
        nvm_bar_data <= 32'h1234_5678;
        @(posedge clock);
        {nvm_load_valid, nvm_reload_done, nvm_bar_valid} <= 3'h0;
        @(posedge clock);
        chk(nvm_reload_busy, 1'b0);
        chk(bar_config, 32'h0);
        axi_read(REG_A, `EDC_NVM_MASK, `EDC_RESP_OKAY);
        chk({seg_offload_flow_setting, seg_offload_setting}, 2'h3);
        system_reboot <= 1'b1;
        @(posedge clock);
        system_reboot <= 1'b0;
        @(posedge clock);
        chk(bar_config, 32'h1234_5678);
        for (int k = 0; k < 4; k++)
        begin
            v = k[1] ? 32'h0 : 32'hB900_0000;
            axi_write(REG_A, v, `EDC_RESP_OKAY);
            msix_fire <= !k[0];
            ext_cause_read <= k[0];
            {irq_cause_access, irq_mask_clear_event} <= 2'h3;
            irq_mask_set_wr <= 1'b1;
            @(posedge clock);
            {msix_fire, ext_cause_read, irq_cause_access} <= 3'h0;
            {irq_mask_clear_event, irq_mask_set_wr} <= 2'h0;
            @(posedge clock);
            chk(ext_auto_mask_clear_valid, k[0] ^ v[24]);
            if (k[0] ^ v[24])
                chk(ext_auto_mask_clear, k[0] ? 32'h5A00 : 32'hA5);
            chk(irq_mask_clear_wr, v[27]);
            chk(irq_timer_clear, v[29]);
            chk(vector_pending_clear, v[31] ? 32'h3C00_0000 : 32'h0);
        end
        end_of_test();
    end
endmodule : testbench

bind edc_ext_ctrl edc_ext_ctrl_chk #(.SPEED_W(SPEED_W), .MASK_W(MASK_W))
    chk_i (.*);
`default_nettype wire
